// >>> logic/port_tag_wake.v
// per-port default 802.1q tag registers and wake event flags, ahb-lite slave
// assumes the port receive path gives one-cycle magic packet pulses on
// CLK_IN and the phys give link and energy levels from another domain
// assumes hready is looped back from this slave's own hreadyout; reads cost
// one wait state and writes none
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "port_tag_wake_consts.vh"

module port_tag_wake #(
    parameter NUM_PORTS = 5,
    parameter NUM_PHY = 4
) (
    input wire CLK_IN,
    input wire RST_IN,
    // ahb-lite slave
    input wire HSEL_IN,
    input wire [31:0] HADDR_IN,
    input wire [1:0] HTRANS_IN,
    input wire HWRITE_IN,
    input wire [2:0] HSIZE_IN,
    input wire [31:0] HWDATA_IN,
    input wire HREADY_IN,
    output wire HREADYOUT_OUT,
    output wire HRESP_OUT,
    output wire [31:0] HRDATA_OUT,
    // event sources
    input wire [NUM_PORTS-1:0] MAGIC_PACKET_IN,
    input wire [NUM_PHY-1:0] LINK_UP_IN,
    input wire [NUM_PHY-1:0] ENERGY_IN,
    // per-port default tags, port index p at [16p+15:16p]
    output wire [16*NUM_PORTS-1:0] PORT_DEFAULT_TAG_OUT,
    output wire WAKE_EVENT_PIN_OUT,
    output wire IRQ_OUT
);

////////////////////////////////////////////////////////////////////////////
// decode helpers

// maps a port nibble to a storage index; 5 and 6 are deliberately missing
function [2:0] port_idx;
    input [3:0] nib;
    begin
        case (nib)
            `PORT_NIB_0: port_idx = 3'h0;
            `PORT_NIB_1: port_idx = 3'h1;
            `PORT_NIB_2: port_idx = 3'h2;
            `PORT_NIB_3: port_idx = 3'h3;
            `PORT_NIB_MAC: port_idx = `PORT_IDX_MAC; // [RULE3]
            default: port_idx = `PORT_IDX_NONE; // [RULE2]
        endcase
    end
endfunction

// byte lane 0 carries all per-port register data; narrower writes must touch it
function lane0_hit;
    input [2:0] size;
    input [1:0] low;
    begin
        if (size == `HSIZE_BYTE) begin
            lane0_hit = (low == 2'h0);
        end else if (size == `HSIZE_HALF) begin
            lane0_hit = (low[1] == 1'b0);
        end else begin
            lane0_hit = 1'b1;
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// input synchronisers and edge detect for phy levels

reg [NUM_PHY-1:0] link_meta_q;
reg [NUM_PHY-1:0] link_sync_q;
reg [NUM_PHY-1:0] link_prev_q;
reg [NUM_PHY-1:0] energy_meta_q;
reg [NUM_PHY-1:0] energy_sync_q;
reg [NUM_PHY-1:0] energy_prev_q;

// three flops per level; the second and third flops feed the edge detector
always @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
        link_meta_q <= {NUM_PHY{1'b0}};
        link_sync_q <= {NUM_PHY{1'b0}};
        link_prev_q <= {NUM_PHY{1'b0}};
        energy_meta_q <= {NUM_PHY{1'b0}};
        energy_sync_q <= {NUM_PHY{1'b0}};
        energy_prev_q <= {NUM_PHY{1'b0}};
    end else begin
        link_meta_q <= LINK_UP_IN;
        link_sync_q <= link_meta_q;
        link_prev_q <= link_sync_q;
        energy_meta_q <= ENERGY_IN;
        energy_sync_q <= energy_meta_q;
        energy_prev_q <= energy_sync_q;
    end
end

// a rising level is a new detection; a level held high sets nothing more
wire [NUM_PHY-1:0] link_rise = link_sync_q & ~link_prev_q;
wire [NUM_PHY-1:0] energy_rise = energy_sync_q & ~energy_prev_q;

////////////////////////////////////////////////////////////////////////////
// ahb-lite address and data phase tracking

// hready is shared, so a read's wait cycle also holds off the next request
wire addr_take = HSEL_IN & HTRANS_IN[`HTRANS_NONSEQ_BIT] & HREADY_IN;

reg wr_pend_q;
reg rd_pend_q;
reg [31:0] addr_q;
reg [2:0] size_q;
reg [31:0] rdata_q;

// reads take one wait state so that a write just before is visible
always @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
        wr_pend_q <= 1'b0;
        rd_pend_q <= 1'b0;
        addr_q <= 32'h00000000;
        size_q <= 3'h0;
    end else begin
        wr_pend_q <= addr_take & HWRITE_IN;
        rd_pend_q <= addr_take & ~HWRITE_IN;
        if (addr_take) begin
            addr_q <= HADDR_IN;
            size_q <= HSIZE_IN;
        end
    end
end

// only a read ever stalls; nothing here can fail, so hresp stays okay
assign HREADYOUT_OUT = ~rd_pend_q;
assign HRESP_OUT = 1'b0;
assign HRDATA_OUT = rdata_q;

// decode of the latched data-phase address
wire [3:0] a_nib = addr_q[`IDX_PORT_HI:`IDX_PORT_LO];
wire [7:0] a_reg = addr_q[`IDX_REG_HI:`IDX_REG_LO];
wire a_zero_ok = (addr_q[`IDX_ZERO_HI:`IDX_ZERO_LO] == 4'h0) &
                 (addr_q[31:18] == 14'h0000);
wire [2:0] a_port = port_idx(a_nib); // [RULE1]
wire a_port_ok = a_zero_ok & (a_port != `PORT_IDX_NONE);
wire a_glob_ok = a_zero_ok & (a_nib == `PORT_NIB_GLOBAL);
wire wr_ok = wr_pend_q & lane0_hit(size_q, addr_q[1:0]);
wire [7:0] wbyte = HWDATA_IN[7:0];

// one select per storage index for the write in its data phase
reg [NUM_PORTS-1:0] port_wsel;
integer k;

always @* begin
    for (k = 0; k < NUM_PORTS; k = k + 1) begin
        port_wsel[k] = wr_ok & a_port_ok & (a_port == k);
    end
end

////////////////////////////////////////////////////////////////////////////
// per-port storage

reg [7:0] tag_hi_q [0:NUM_PORTS-1];
reg [7:0] tag_lo_q [0:NUM_PORTS-1];
reg [7:0] wake_en_q [0:NUM_PORTS-1];
reg [7:0] wake_evt_q [0:NUM_PORTS-1];
reg [14:0] irq_stat_q;
reg [14:0] irq_mask_q;

// event set vector per port: {magic, link, energy}
reg [7:0] set_vec [0:NUM_PORTS-1];
reg [7:0] used_mask [0:NUM_PORTS-1];
integer s;

// the mac port has no phy, so its link and energy bits never exist
always @* begin
    for (s = 0; s < NUM_PORTS; s = s + 1) begin
        set_vec[s] = 8'h00;
        used_mask[s] = `WAKE_MAC_MASK;
        set_vec[s][`WAKE_BIT_MAGIC] = MAGIC_PACKET_IN[s]; // [RULE6]
        if (s < NUM_PHY) begin
            used_mask[s] = `WAKE_USED_MASK;
            set_vec[s][`WAKE_BIT_LINK] = link_rise[s]; // [RULE7]
            set_vec[s][`WAKE_BIT_ENERGY] = energy_rise[s]; // [RULE8]
        end
    end
end

reg [7:0] wake_evt_d [0:NUM_PORTS-1];
integer c;

// ones written clear; a new detection in the same cycle wins over the clear
always @* begin
    for (c = 0; c < NUM_PORTS; c = c + 1) begin
        wake_evt_d[c] = wake_evt_q[c] | set_vec[c]; // [RULE10]
        if (port_wsel[c] && a_reg == `REG_WAKE_EVENT) begin
            wake_evt_d[c] = (wake_evt_q[c] & ~wbyte) | set_vec[c]; // [RULE6]
        end
        // missing bits never set, so reserved ones always read zero
        wake_evt_d[c] = wake_evt_d[c] & used_mask[c]; // [RULE7] [RULE8]
    end
end

integer p;

// register writes, event capture and write-clear of the event flags
always @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
        for (p = 0; p < NUM_PORTS; p = p + 1) begin
            tag_hi_q[p] <= `TAG_HIGH_RST; // [RULE4]
            tag_lo_q[p] <= `TAG_LOW_RST; // [RULE5]
            wake_en_q[p] <= `WAKE_ENABLE_RST;
            wake_evt_q[p] <= `WAKE_EVENT_RST;
        end
    end else begin
        for (p = 0; p < NUM_PORTS; p = p + 1) begin
            if (port_wsel[p]) begin
                if (a_reg == `REG_TAG_HIGH) begin
                    tag_hi_q[p] <= wbyte; // [RULE4]
                end
                if (a_reg == `REG_TAG_LOW) begin
                    tag_lo_q[p] <= wbyte; // [RULE5]
                end
                if (a_reg == `REG_WAKE_ENABLE) begin
                    wake_en_q[p] <= wbyte & used_mask[p];
                end
            end
            wake_evt_q[p] <= wake_evt_d[p]; // [RULE10]
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// interrupt status and mask

// flat event vector in status layout, port p at bits 3p+2..3p
reg [14:0] evt_flat;
integer f;

always @* begin
    evt_flat = 15'h0000;
    for (f = 0; f < NUM_PORTS; f = f + 1) begin
        evt_flat[3*f +: 3] = set_vec[f][2:0] & used_mask[f][2:0];
    end
end

// read of the status word clears what was returned; later events survive
wire stat_read = rd_pend_q & a_glob_ok & (a_reg == `REG_IRQ_STATUS);

reg [14:0] irq_stat_d;
reg [14:0] irq_mask_d;
reg irq_q;

// next status and mask; the clear keeps an event that lands with it
always @* begin
    irq_stat_d = irq_stat_q | evt_flat;
    if (stat_read) begin
        irq_stat_d = evt_flat;
    end
    irq_mask_d = irq_mask_q;
    if (wr_ok && a_glob_ok && a_reg == `REG_IRQ_MASK) begin
        irq_mask_d = HWDATA_IN[14:0];
    end
end

// the pin flop looks at the next values, so it follows the registers
// with no extra cycle while still leaving the block from a flip-flop
always @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
        irq_stat_q <= 15'h0000;
        irq_mask_q <= `IRQ_MASK_RST;
        irq_q <= 1'b0;
    end else begin
        irq_stat_q <= irq_stat_d;
        irq_mask_q <= irq_mask_d;
        irq_q <= |(irq_stat_d & irq_mask_d);
    end
end

assign IRQ_OUT = irq_q;

////////////////////////////////////////////////////////////////////////////
// read data

reg [31:0] rd_mux;

// unmapped addresses and reserved bits read as zero
always @* begin
    rd_mux = 32'h00000000;
    if (a_port_ok) begin
        case (a_reg)
            `REG_TAG_HIGH: rd_mux[7:0] = tag_hi_q[a_port];
            `REG_TAG_LOW: rd_mux[7:0] = tag_lo_q[a_port];
            `REG_WAKE_EVENT: rd_mux[7:0] = wake_evt_q[a_port]; // [RULE10]
            `REG_WAKE_ENABLE: rd_mux[7:0] = wake_en_q[a_port];
            default: rd_mux = 32'h00000000;
        endcase
    end else if (a_glob_ok) begin
        case (a_reg)
            `REG_IRQ_STATUS: rd_mux[14:0] = irq_stat_q;
            `REG_IRQ_MASK: rd_mux[14:0] = irq_mask_q;
            default: rd_mux = 32'h00000000;
        endcase
    end
end

// captured in the wait cycle and held until the next read
always @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
        rdata_q <= 32'h00000000;
    end else if (rd_pend_q) begin
        rdata_q <= rd_mux;
    end
end

////////////////////////////////////////////////////////////////////////////
// outputs: wake pin and default tags

reg wake_q;
reg [16*NUM_PORTS-1:0] tag_out_q;
reg wake_d;
reg [16*NUM_PORTS-1:0] tag_d;
integer w;

// an event raises the pin only through its own enable bit
always @* begin
    wake_d = 1'b0;
    tag_d = {16*NUM_PORTS{1'b0}};
    for (w = 0; w < NUM_PORTS; w = w + 1) begin
        wake_d = wake_d | (|(wake_evt_q[w] & wake_en_q[w])); // [RULE9]
        tag_d[16*w +: 16] = {tag_hi_q[w], tag_lo_q[w]};
    end
end

always @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
        wake_q <= 1'b0;
        tag_out_q <= {NUM_PORTS{`TAG_HIGH_RST, `TAG_LOW_RST}};
    end else begin
        wake_q <= wake_d;
        tag_out_q <= tag_d;
    end
end

assign WAKE_EVENT_PIN_OUT = wake_q;
assign PORT_DEFAULT_TAG_OUT = tag_out_q;

endmodule

// >>> logic/port_tag_wake_consts.vh
// constants for the per-port default tag and wake event register slice
// assumes an ahb-lite word bus: byte address = 4 x register index
//
// Contract
// (RULE1) every port keeps its own register copy, picked by the port nibble.
// (RULE2) nibbles 1-4 and 7 reach port registers, 7 mac-only, 1-4 phy-only.
// (RULE3) the mac port, logical port 5, is reached with nibble 7, never 5.
// (RULE4) tag high is rw, resets 0: priority 7:5, drop-eligible 4, vid 11:8.
// (RULE5) tag low is rw, holds vid 7:0 and resets to 0x01, so vlan 1.
// (RULE6) bit 2 sets on a switch-mac magic packet, read-only, write clears.
// (RULE7) bit 1 sets on link-up, phy ports only, read-only, write clears.
// (RULE8) bit 0 sets on cable energy, phy ports only, read-only, write clears.
// (RULE9) the wake pin rises for an event only through its own enable bit.
// (RULE10) event bits stay set until a write clears them; bits 7:3 read 0.

`ifndef PORT_TAG_WAKE_CONSTS_VH
`define PORT_TAG_WAKE_CONSTS_VH

// register indices inside one port range
`define REG_TAG_HIGH 8'h00
`define REG_TAG_LOW 8'h01
`define REG_WAKE_EVENT 8'h13
`define REG_WAKE_ENABLE 8'h17

// index fields: haddr[17:14] port nibble, [13:10] zero, [9:2] register
`define IDX_PORT_HI 17
`define IDX_PORT_LO 14
`define IDX_ZERO_HI 13
`define IDX_ZERO_LO 10
`define IDX_REG_HI 9
`define IDX_REG_LO 2

// accepted port nibbles, in port index order 0..4
`define PORT_NIB_0 4'h1
`define PORT_NIB_1 4'h2
`define PORT_NIB_2 4'h3
`define PORT_NIB_3 4'h4
`define PORT_NIB_MAC 4'h7
`define PORT_IDX_NONE 3'h7
`define PORT_IDX_MAC 3'h4

// global interrupt registers, in the otherwise unused port nibble f
`define PORT_NIB_GLOBAL 4'hf
`define REG_IRQ_STATUS 8'h00
`define REG_IRQ_MASK 8'h04

// reset values
`define TAG_HIGH_RST 8'h00
`define TAG_LOW_RST 8'h01
`define WAKE_EVENT_RST 8'h00
`define WAKE_ENABLE_RST 8'h00
`define IRQ_MASK_RST 15'h0000

// wake event and enable bit positions
`define WAKE_BIT_MAGIC 2
`define WAKE_BIT_LINK 1
`define WAKE_BIT_ENERGY 0
`define WAKE_USED_MASK 8'h07
`define WAKE_MAC_MASK 8'h04

// ahb-lite encodings
`define HTRANS_NONSEQ_BIT 1
`define HSIZE_BYTE 3'h0
`define HSIZE_HALF 3'h1

`endif

// >>> verification/port_tag_wake_chk.sv
// assertions on the port tag and wake slice, top-level ports only
// assumes hready is looped back from the slave's own hreadyout
`timescale 1ns/1ps
module port_tag_wake_chk #(
    parameter NUM_PORTS = 5,
    parameter NUM_PHY = 4
) (
    input wire CLK_IN,
    input wire RST_IN,
    input wire HSEL_IN,
    input wire [31:0] HADDR_IN,
    input wire [1:0] HTRANS_IN,
    input wire HWRITE_IN,
    input wire [2:0] HSIZE_IN,
    input wire [31:0] HWDATA_IN,
    input wire HREADY_IN,
    input wire HREADYOUT_OUT,
    input wire HRESP_OUT,
    input wire [31:0] HRDATA_OUT,
    input wire [16*NUM_PORTS-1:0] PORT_DEFAULT_TAG_OUT,
    input wire WAKE_EVENT_PIN_OUT
);
    // transfers taken at this edge; only whole words count as writes here
    wire go = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
    wire wr_go = go & HWRITE_IN & (HSIZE_IN == 3'h2);
    wire rd_go = go & ~HWRITE_IN;

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (RST_IN);

    ////////////////////////////////////////////////////////////////////
    a_resp_okay:
        assert property (HRESP_OUT == 1'b0) else $error("hresp not okay");
    a_read_wait:
        assert property (rd_go |=> !HREADYOUT_OUT ##1 HREADYOUT_OUT)
        else $error("read wait not one cycle");
    a_write_nowait:
        assert property (wr_go |=> HREADYOUT_OUT) else $error("write stall");
    a_tag_high:
        assert property (wr_go && HADDR_IN == 32'h4000 |=> ##2
            PORT_DEFAULT_TAG_OUT[15:8] == $past(HWDATA_IN[7:0], 2))
        else $error("tag high write lost");
    a_mac_tag_low:
        assert property (wr_go && HADDR_IN == 32'h1c004 |=> ##2
            PORT_DEFAULT_TAG_OUT[71:64] == $past(HWDATA_IN[7:0], 2))
        else $error("mac tag low write lost");
    a_nib_five:
        assert property (wr_go && HADDR_IN[17:14] == 4'h5 |=> ##2
            $stable(PORT_DEFAULT_TAG_OUT)) else $error("nibble 5 decoded");
    a_nib_zero:
        assert property (wr_go && HADDR_IN[17:14] == 4'h0 |=> ##2
            $stable(PORT_DEFAULT_TAG_OUT)) else $error("nibble 0 decoded");
    a_resv_zero:
        assert property (rd_go && HADDR_IN[9:2] == 8'h13 |=> ##1
            HRDATA_OUT[31:3] == 29'h0) else $error("event reserved set");
    a_wake_sticky:
        assert property ($fell(WAKE_EVENT_PIN_OUT) |-> $past(wr_go, 2) ||
            $past(wr_go, 3) || $past(wr_go, 4)) else $error("wake dropped");
endmodule

bind port_tag_wake port_tag_wake_chk #(.NUM_PORTS(NUM_PORTS),
    .NUM_PHY(NUM_PHY)) i_chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
    .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN),
    .HWRITE_IN(HWRITE_IN), .HSIZE_IN(HSIZE_IN), .HWDATA_IN(HWDATA_IN),
    .HREADY_IN(HREADY_IN), .HREADYOUT_OUT(HREADYOUT_OUT),
    .HRESP_OUT(HRESP_OUT), .HRDATA_OUT(HRDATA_OUT),
    .PORT_DEFAULT_TAG_OUT(PORT_DEFAULT_TAG_OUT),
    .WAKE_EVENT_PIN_OUT(WAKE_EVENT_PIN_OUT));

// >>> verification/test_port_tag_wake.sv
// self-checking bench for the port tag and wake slice
// drives the ahb-lite bus and the event inputs itself, 40 mhz clock
`timescale 1ns/1ps
module test_port_tag_wake;
    logic CLK_IN, RST_IN, HSEL_IN, HWRITE_IN;
    logic [31:0] HADDR_IN, HWDATA_IN, rd_val;
    logic [1:0] HTRANS_IN;
    logic [2:0] HSIZE_IN;
    logic [4:0] MAGIC_PACKET_IN;
    logic [3:0] LINK_UP_IN, ENERGY_IN;
    wire [31:0] HRDATA_OUT;
    wire [79:0] PORT_DEFAULT_TAG_OUT;
    wire HREADYOUT_OUT, HRESP_OUT, WAKE_EVENT_PIN_OUT, IRQ_OUT;
    int fail_count = 0;
    int checked = 0;
    typedef struct {logic [31:0] a, d, e;} row_t;
    logic [3:0] nibs[5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7};
    // address, write data, read-back expected
    row_t rows[10] = '{
        '{32'h4000, 32'hff, 32'hff},  // tag high rw
        '{32'h8004, 32'h5a, 32'h5a},  // tag low rw
        '{32'hc05c, 32'hff, 32'h07},  // phy enable
        '{32'h1c05c, 32'hff, 32'h04}, // mac enable
        '{32'h1c000, 32'he5, 32'he5}, // mac via 7
        '{32'h1c004, 32'h3c, 32'h3c}, // mac tag low
        '{32'h14000, 32'haa, 32'h00}, // nibble 5
        '{32'h0000, 32'haa, 32'h00},  // nibble 0
        '{32'h2c000, 32'haa, 32'h00}, // nibble b
        '{32'h1004c, 32'hff, 32'h00}  // read-only
    };

    port_tag_wake i_dut (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
        .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN),
        .HWRITE_IN(HWRITE_IN), .HSIZE_IN(HSIZE_IN), .HWDATA_IN(HWDATA_IN),
        .HREADY_IN(HREADYOUT_OUT), .HREADYOUT_OUT(HREADYOUT_OUT),
        .HRESP_OUT(HRESP_OUT), .HRDATA_OUT(HRDATA_OUT),
        .MAGIC_PACKET_IN(MAGIC_PACKET_IN), .LINK_UP_IN(LINK_UP_IN),
        .ENERGY_IN(ENERGY_IN), .PORT_DEFAULT_TAG_OUT(PORT_DEFAULT_TAG_OUT),
        .WAKE_EVENT_PIN_OUT(WAKE_EVENT_PIN_OUT), .IRQ_OUT(IRQ_OUT));

    // 25 ns period
    initial begin
        CLK_IN = 1'b0;
        forever #12.5 CLK_IN = ~CLK_IN;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        if (fail_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    // bounded wait for hready at a rising edge; a hang ends the run
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge CLK_IN);
        while (HREADYOUT_OUT !== 1'b1) begin
            n++;
            if (n > 40) begin
                fail_count++;
                wrap_up;
            end
            @(posedge CLK_IN);
        end
    endtask

    // one single word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [31:0] a, d);
        @(posedge CLK_IN);
        HSEL_IN <= 1'b1;
        HTRANS_IN <= 2'h2;
        HADDR_IN <= a;
        HWRITE_IN <= w;
        wait_rdy;
        HTRANS_IN <= 2'h0;
        HWDATA_IN <= d;
        wait_rdy;
        rd_val = HRDATA_OUT;
        HSEL_IN <= 1'b0;
    endtask

    task automatic rchk(input string nm, input logic [31:0] a, e);
        bus(1'b0, a, 32'h0);
        cmp(nm, e, rd_val);
    endtask

    task automatic magic(input logic [4:0] m);
        @(posedge CLK_IN);
        MAGIC_PACKET_IN <= m;
        @(posedge CLK_IN);
        MAGIC_PACKET_IN <= 5'h00;
        repeat (3) @(posedge CLK_IN);
    endtask

    function automatic logic [31:0] nb(input logic [3:0] n);
        return {14'h0, n, 14'h0};
    endfunction

    function automatic logic [31:0] tg(input int i);
        return {16'h0, PORT_DEFAULT_TAG_OUT[16*i +: 16]};
    endfunction

    task automatic rst_chk;
        foreach (nibs[i]) begin
            rchk("tag hi", nb(nibs[i]), 32'h00);
            rchk("tag lo", nb(nibs[i]) + 32'h4, 32'h01);
            rchk("event", nb(nibs[i]) + 32'h4c, 32'h00);
            cmp("tag out", 32'h0001, tg(i));
        end
        cmp("wake", 32'h0, {31'h0, WAKE_EVENT_PIN_OUT});
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        RST_IN <= 1'b1;
        HSEL_IN <= 1'b0;
        HADDR_IN <= 32'h0;
        HTRANS_IN <= 2'h0;
        HWRITE_IN <= 1'b0;
        HSIZE_IN <= 3'h2;
        HWDATA_IN <= 32'h0;
        MAGIC_PACKET_IN <= 5'h00;
        LINK_UP_IN <= 4'h0;
        ENERGY_IN <= 4'h0;
        repeat (8) @(posedge CLK_IN);
        RST_IN <= 1'b0;
        rst_chk;
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].d);
            rchk("table", rows[i].a, rows[i].e);
        end
        cmp("port1 tag", 32'hff01, tg(0));
        cmp("mac tag", 32'he53c, tg(4));
        // magic with enable off: flag sticks, pin stays low
        magic(5'h01);
        cmp("wake off", 32'h0, {31'h0, WAKE_EVENT_PIN_OUT});
        rchk("magic", 32'h404c, 32'h04);
        rchk("sticky", 32'h404c, 32'h04);
        bus(1'b1, 32'h405c, 32'h04);
        repeat (3) @(posedge CLK_IN);
        cmp("wake on", 32'h1, {31'h0, WAKE_EVENT_PIN_OUT});
        bus(1'b1, 32'h404c, 32'h00);
        rchk("zero keeps", 32'h404c, 32'h04);
        bus(1'b1, 32'h404c, 32'h04);
        rchk("one clears", 32'h404c, 32'h00);
        // phy events cross two sync stages, so give them six edges
        LINK_UP_IN[1] <= 1'b1;
        ENERGY_IN[3] <= 1'b1;
        magic(5'h10);
        repeat (6) @(posedge CLK_IN);
        rchk("link", 32'h804c, 32'h02);
        rchk("energy", 32'h1004c, 32'h01);
        rchk("mac magic", 32'h1c04c, 32'h04);
        bus(1'b1, 32'h804c, 32'h02);
        rchk("link clr", 32'h804c, 32'h00);
        // status collects every event so far while all are masked
        cmp("irq masked", 32'h0, {31'h0, IRQ_OUT});
        rchk("status", 32'h3c000, 32'h4214);
        bus(1'b1, 32'h3c010, 32'h0004);
        ENERGY_IN[0] <= 1'b1;
        repeat (6) @(posedge CLK_IN);
        cmp("irq unmask", 32'h0, {31'h0, IRQ_OUT});
        magic(5'h01);
        cmp("irq on", 32'h1, {31'h0, IRQ_OUT});
        rchk("status2", 32'h3c000, 32'h0005);
        cmp("irq clr", 32'h0, {31'h0, IRQ_OUT});
        // mid-run reset with levels dropped first to avoid fresh edges
        LINK_UP_IN <= 4'h0;
        ENERGY_IN <= 4'h0;
        repeat (6) @(posedge CLK_IN);
        RST_IN <= 1'b1;
        repeat (2) @(posedge CLK_IN);
        RST_IN <= 1'b0;
        rst_chk;
        wrap_up;
    end
endmodule
